// file: timer_regs.svh
// register layout and address constants for the three channel timer
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH
`define CW_SEL_HI 7
`define CW_SEL_LO 6
`define CW_FMT_HI 5
`define CW_FMT_LO 4
`define CW_M_HI 3
`define CW_M_LO 1
`define CW_BCD 0
`define SEL_READBACK 2'h3
`define FMT_LATCH 2'h0
`define FMT_LOW 2'h1
`define FMT_HIGH 2'h2
`define FMT_BOTH 2'h3
`define ADDR_COUNT0 2'h0
`define ADDR_COUNT1 2'h1
`define ADDR_COUNT2 2'h2
`define ADDR_CONTROL 2'h3
`define HOST_CMD_CTRL 4'h0
`define HOST_CMD_DATA 4'h1
`define HOST_STATUS 4'h2
`define HOST_OUTPUTS 4'h3
`define HOST_GATES 4'h4
`define HOST_CLOCKS 4'h5
`endif

// file: timer_pkg.sv
// types shared by both ends of the three channel timer
package timer_pkg;
    typedef enum logic [2:0] {
        MODE0 = 3'b001,
        MODE1 = 3'b010,
        MODE2 = 3'b100
    } mode_e;
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_WRITE = 3'b010,
        H_DONE = 3'b100
    } host_state_e;
endpackage

// file: timer_if.sv
// link between host and timer: byte write port plus per channel clock and gate
`timescale 1ns/1ps
interface timer_if;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [2:0] cnt_clk;
    logic [2:0] gate;
    logic [2:0] tout;
    modport device (
        input addr,
        input wdata,
        input wr,
        input cnt_clk,
        input gate,
        output tout
    );
    modport host (
        output addr,
        output wdata,
        output wr,
        output cnt_clk,
        output gate,
        input tout
    );
endinterface

// file: timer_device.sv
// three channel down counting timer, modes 0 to 2
// Summary of operation
// R1 - select field picks channel; code 11 is read-back, ignored here with no action
// R2 - access format: latch, low, high, low then high; latch words are ignored here
// R3 - mode field decode, top bit ignored modes 2-3
// R4 - zero count means maximum count
// R5 - host keeps count at least 2 or 1
// R6 - bcd bit selects decimal down counting
// R7 - control word clears counter, zero unreadable
// R8 - host writes control word before count
// R9 - host writes bytes in selected format
// R10 - per channel partial byte state kept
// R11 - mode 0 output low until terminal count
// R12 - mode 0 load edge does not decrement
// R13 - mode 0 gate pauses counting only
// R14 - mode 0 first byte suspends, forces low
// R15 - mode 0 gate low load, no extra clock
// R16 - mode 1 trigger loads, low N clocks
// R17 - mode 1 gate rise retriggers with reload
// R18 - mode 1 new count waits for retrigger
// R19 - mode 2 low pulse at one, reload
// R20 - mode 2 gate low halts, forces high
// R21 - mode 2 first low N clocks after write
// R22 - mode 2 new count at trigger or cycle end
// R23 - host never writes count 1 in mode 2
// R24 - gate rise held until next count edge
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_device (
    input wire logic clk,
    input wire logic reset_n,
    timer_if.device bus
);
    typedef struct packed {
        timer_pkg::mode_e mode;
        logic bcd;
        logic [1:0] fmt;
        logic [15:0] hold;
        logic [15:0] count;
        logic hi_next;
        logic load_pending;
        logic armed;
        logic running;
        logic trig;
        logic gate_prev;
        logic clk_prev;
        logic out;
    } chan_s;
    typedef struct packed {
        chan_s [2:0] ch;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // decimal down count by one, each nibble wraps 0 to 9
    function automatic logic [15:0] dec_one(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001; // R6
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (borrow) begin
                    if (r[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9; // R6
                    end else begin
                        r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    always_comb begin
        logic fall;
        logic gate_rise;
        logic [1:0] sel;
        logic [2:0] mbits;
        logic [15:0] nxt;
        fall = 1'b0;
        gate_rise = 1'b0;
        sel = 2'h0;
        mbits = 3'h0;
        nxt = 16'h0000;
        state_next = state_reg;
        for (int i = 0; i < 3; i++) begin
            fall = state_reg.ch[i].clk_prev & ~bus.cnt_clk[i];
            gate_rise = bus.gate[i] & ~state_reg.ch[i].gate_prev;
            state_next.ch[i].clk_prev = bus.cnt_clk[i];
            state_next.ch[i].gate_prev = bus.gate[i];
            if (gate_rise) begin
                state_next.ch[i].trig = 1'b1; // R24
            end
            // mode 2 gate low forces output high at once
            if (state_reg.ch[i].mode == timer_pkg::MODE2 && !bus.gate[i]) begin
                state_next.ch[i].out = 1'b1; // R20
            end
            if (fall) begin
                state_next.ch[i].trig = gate_rise;
                nxt = dec_one(state_reg.ch[i].count, state_reg.ch[i].bcd);
                case (state_reg.ch[i].mode)
                    timer_pkg::MODE0: begin
                        if (state_reg.ch[i].load_pending) begin
                            state_next.ch[i].count = state_reg.ch[i].hold; // R12 R15
                            state_next.ch[i].load_pending = 1'b0;
                            state_next.ch[i].running = 1'b1;
                        end else if (state_reg.ch[i].running && bus.gate[i]) begin // R13
                            state_next.ch[i].count = nxt; // R4
                            if (nxt == 16'h0000) begin
                                state_next.ch[i].out = 1'b1; // R11
                                state_next.ch[i].running = 1'b0;
                            end
                        end
                    end
                    timer_pkg::MODE1: begin
                        if (state_reg.ch[i].trig && state_reg.ch[i].armed) begin
                            state_next.ch[i].count = state_reg.ch[i].hold; // R16 R17 R18
                            state_next.ch[i].out = 1'b0; // R16
                            state_next.ch[i].running = 1'b1;
                        end else if (state_reg.ch[i].running) begin
                            state_next.ch[i].count = nxt;
                            if (nxt == 16'h0000) begin
                                state_next.ch[i].out = 1'b1; // R16
                                state_next.ch[i].running = 1'b0;
                            end
                        end
                    end
                    timer_pkg::MODE2: begin
                        // a count written mid-cycle waits for a trigger or the cycle end
                        if (state_reg.ch[i].armed && ((state_reg.ch[i].load_pending && !state_reg.ch[i].running)
                                || state_reg.ch[i].trig)) begin
                            state_next.ch[i].count = state_reg.ch[i].hold; // R20 R21 R22
                            state_next.ch[i].load_pending = 1'b0;
                            state_next.ch[i].running = 1'b1;
                            state_next.ch[i].out = 1'b1;
                        end else if (state_reg.ch[i].running && bus.gate[i]) begin
                            if (state_reg.ch[i].count == 16'h0001) begin
                                state_next.ch[i].count = state_reg.ch[i].hold; // R19 R22
                                state_next.ch[i].load_pending = 1'b0;
                                state_next.ch[i].out = 1'b1;
                            end else begin
                                state_next.ch[i].count = nxt;
                                state_next.ch[i].out = (nxt != 16'h0001); // R19
                            end
                        end
                    end
                    default: begin
                        state_next.ch[i].running = 1'b0;
                    end
                endcase
            end
        end
        if (bus.wr) begin
            if (bus.addr == `ADDR_CONTROL) begin
                sel = bus.wdata[`CW_SEL_HI:`CW_SEL_LO];
                mbits = bus.wdata[`CW_M_HI:`CW_M_LO];
                // read-back and latch need no write action since readback is absent
                if (sel != `SEL_READBACK && bus.wdata[`CW_FMT_HI:`CW_FMT_LO] != `FMT_LATCH) begin // R1 R2
                    state_next.ch[sel].fmt = bus.wdata[`CW_FMT_HI:`CW_FMT_LO];
                    state_next.ch[sel].bcd = bus.wdata[`CW_BCD];
                    state_next.ch[sel].count = 16'h0000; // R7
                    state_next.ch[sel].hi_next = 1'b0;
                    state_next.ch[sel].load_pending = 1'b0;
                    state_next.ch[sel].armed = 1'b0;
                    state_next.ch[sel].running = 1'b0;
                    state_next.ch[sel].trig = 1'b0;
                    if (mbits == 3'h0) begin // R3
                        state_next.ch[sel].mode = timer_pkg::MODE0;
                        state_next.ch[sel].out = 1'b0; // R11
                    end else if (mbits == 3'h1) begin
                        state_next.ch[sel].mode = timer_pkg::MODE1;
                        state_next.ch[sel].out = 1'b1; // R16
                    end else begin
                        // modes 3 to 5 are not built; they fall back to the rate generator
                        state_next.ch[sel].mode = timer_pkg::MODE2;
                        state_next.ch[sel].out = 1'b1; // R19
                    end
                end
            end else begin
                sel = bus.addr;
                case (state_reg.ch[sel].fmt)
                    `FMT_LOW: begin
                        state_next.ch[sel].hold = {8'h00, bus.wdata};
                        state_next.ch[sel].load_pending = 1'b1;
                        state_next.ch[sel].armed = 1'b1;
                    end
                    `FMT_HIGH: begin
                        state_next.ch[sel].hold = {bus.wdata, 8'h00};
                        state_next.ch[sel].load_pending = 1'b1;
                        state_next.ch[sel].armed = 1'b1;
                    end
                    `FMT_BOTH: begin
                        if (!state_reg.ch[sel].hi_next) begin
                            state_next.ch[sel].hold[7:0] = bus.wdata; // R10
                            state_next.ch[sel].hi_next = 1'b1;
                            if (state_reg.ch[sel].mode == timer_pkg::MODE0) begin
                                state_next.ch[sel].running = 1'b0; // R14
                                state_next.ch[sel].load_pending = 1'b0;
                                state_next.ch[sel].out = 1'b0; // R14
                            end
                        end else begin
                            state_next.ch[sel].hold[15:8] = bus.wdata; // R10
                            state_next.ch[sel].hi_next = 1'b0;
                            state_next.ch[sel].load_pending = 1'b1; // R14
                            state_next.ch[sel].armed = 1'b1;
                        end
                    end
                    default: begin
                        state_next.ch[sel].hi_next = 1'b0;
                    end
                endcase
                // mode 1 loads only on a trigger, never on a write
                if (state_reg.ch[sel].mode == timer_pkg::MODE1) begin
                    state_next.ch[sel].load_pending = 1'b0; // R18
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                state_reg.ch[i] <= '{mode: timer_pkg::MODE0, fmt: `FMT_BOTH, out: 1'b1, default: '0};
            end
        end else begin
            state_reg <= state_next;
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_out
        assign bus.tout[g] = state_reg.ch[g].out;
    end
endmodule

// file: timer_host.sv
// host end: register port commands drive control words, counts, clocks and gates
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_host (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    timer_if.host bus
);
    typedef struct packed {
        timer_pkg::host_state_e st;
        logic [1:0] waddr;
        logic [7:0] wbyte;
        logic [2:0] clks;
        logic [2:0] gates;
        logic [2:0] outs;
        logic [7:0] rdata;
        logic writes_done;
    } host_s;

    host_s state_reg;
    host_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.rdata = 8'h00;
        state_next.outs = bus.tout;
        case (state_reg.st)
            timer_pkg::H_IDLE: begin
            end
            // one cycle with the write strobe raised toward the timer
            timer_pkg::H_WRITE: begin
                state_next.st = timer_pkg::H_DONE;
            end
            timer_pkg::H_DONE: begin
                state_next.st = timer_pkg::H_IDLE;
                state_next.writes_done = 1'b1;
            end
            default: begin
                state_next.st = timer_pkg::H_IDLE;
            end
        endcase
        if (wr) begin
            case (addr)
                // the host keeps R8 R9 R5 R23 by software; this end only forwards bytes
                `HOST_CMD_CTRL: begin
                    state_next.waddr = `ADDR_CONTROL; // R8
                    state_next.wbyte = wdata;
                    state_next.st = timer_pkg::H_WRITE;
                end
                `HOST_CMD_DATA: begin
                    state_next.waddr = wdata[1:0];
                    state_next.writes_done = 1'b0;
                end
                `HOST_STATUS: begin
                    state_next.wbyte = wdata; // R9
                    state_next.st = timer_pkg::H_WRITE;
                end
                `HOST_GATES: state_next.gates = wdata[2:0];
                `HOST_CLOCKS: state_next.clks = wdata[2:0];
                // unmapped writes are dropped without disturbing a byte in flight
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (addr)
                `HOST_OUTPUTS: state_next.rdata = {5'h00, state_reg.outs};
                `HOST_STATUS: state_next.rdata = {7'h00, state_reg.writes_done};
                `HOST_GATES: state_next.rdata = {5'h00, state_reg.gates};
                `HOST_CLOCKS: state_next.rdata = {5'h00, state_reg.clks};
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '{st: timer_pkg::H_IDLE, clks: 3'h7, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign bus.addr = state_reg.waddr;
    assign bus.wdata = state_reg.wbyte;
    assign bus.wr = (state_reg.st == timer_pkg::H_WRITE);
    assign bus.cnt_clk = state_reg.clks;
    assign bus.gate = state_reg.gates;
endmodule

// file: timer_chk.sv
// assertions on the link between the host end and the timer end
`timescale 1ns/1ps
module timer_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic [2:0] cnt_clk,
    input wire logic [2:0] gate,
    input wire logic [2:0] tout
);
    logic [2:0] clk_q;
    logic [2:0] fall;
    logic [7:0] cw_q [3];
    logic cw_wr;
    logic cw_ok;
    assign fall = clk_q & ~cnt_clk;
    assign cw_wr = wr && addr == 2'h3;
    assign cw_ok = cw_wr && wdata[7:6] != 2'h3 && wdata[5:4] != 2'h0;
    // refused words must not touch the copy, or the mode checks below would judge the wrong mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_q <= 3'h7;
            for (int i = 0; i < 3; i++) begin
                cw_q[i] <= 8'h30;
            end
        end else begin
            clk_q <= cnt_clk;
            if (cw_ok) begin
                cw_q[wdata[7:6]] <= wdata;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_cw_sets_low: assert property (cw_ok && wdata[7:6] == 2'h0 && wdata[3:1] == 3'h0 |=> !tout[0])
        else $error("mode 0 control word left output high");
    a_cw_sets_high: assert property (cw_ok && wdata[3:1] != 3'h0 |=> tout[$past(wdata[7:6])])
        else $error("control word left output low");
    a_readback_ignored: assert property (cw_wr && wdata[7:6] == 2'h3 && fall == 3'h0 && $stable(gate)
        |=> $stable(tout)) else $error("read-back code changed an output");
    a_latch_ignored: assert property (cw_wr && wdata[7:6] != 2'h3 && wdata[5:4] == 2'h0 && fall == 3'h0
        && $stable(gate) |=> $stable(tout)) else $error("latch format changed an output");
    a_m0_rise_fall: assert property (cw_q[0][3:1] == 3'h0 && $rose(tout[0])
        |-> $past(fall[0]) && $past(gate[0])) else $error("mode 0 output rose without a counting edge");
    a_m0_count_low: assert property (wr && addr == 2'h0 && cw_q[0][5:1] == 5'h18 |=> !tout[0])
        else $error("mode 0 count byte left output high");
    a_m1_fall_clk: assert property (cw_q[1][3:1] == 3'h1 && $fell(tout[1]) |-> $past(fall[1]))
        else $error("mode 1 pulse began off a count edge");
    a_m2_low_clk: assert property (cw_q[2][2:1] == 2'h2 && $fell(tout[2]) |-> $past(fall[2] & gate[2]))
        else $error("mode 2 low pulse began off a counting edge");
    a_m2_rise_cause: assert property (cw_q[2][2:1] == 2'h2 && $rose(tout[2])
        |-> $past(fall[2] | ~gate[2] | wr)) else $error("mode 2 output rose without a cause");
    a_m2_gate_force: assert property (cw_q[2][2:1] == 2'h2 && !gate[2] && !tout[2] && !wr
        |-> ##[1:2] tout[2]) else $error("mode 2 low gate did not force output high");
endmodule

// file: tb_three_channel_timer_modes_0_to_2.sv
// self-checking bench: register port drives the host end, which drives the timer end
`timescale 1ns/1ps
module tb_three_channel_timer_modes_0_to_2;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'h967AB5B7;
    int num_errors = 0;
    int n_compared = 0;
    timer_if tif ();
    timer_device timer_device_inst (.clk(clk), .reset_n(reset_n), .bus(tif.device));
    timer_host timer_host_inst (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .bus(tif.host));
    timer_chk timer_chk_inst (.clk(clk), .reset_n(reset_n), .addr(tif.addr), .wdata(tif.wdata), .wr(tif.wr),
        .cnt_clk(tif.cnt_clk), .gate(tif.gate), .tout(tif.tout));
    always #5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: read %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // two idle cycles after each write keep byte commands apart on the link
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic get(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // count clocks idle high; one tick is a fall then a return high
    task automatic ticks(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            put(4'h5, 8'h07 & ~(8'h01 << ch));
            put(4'h5, 8'h07);
        end
    endtask
    always @(posedge clk) begin
        if (rd_seen) begin
            check(rdata, exp_q.pop_front());
        end
        rd_seen <= rd;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        put(4'h0, 8'hF0);
        put(4'h0, 8'h00);
        get(4'h3, 8'h07);
        $display("refused control words done");
        put(4'h0, 8'h30);
        get(4'h3, 8'h06);
        put(4'h1, 8'h00);
        put(4'h2, 8'h01);
        put(4'h2, 8'h00);
        get(4'h2, 8'h01);
        ticks(0, 3);
        get(4'h3, 8'h06);
        put(4'h4, 8'h07);
        ticks(0, 1);
        get(4'h3, 8'h07);
        put(4'h2, 8'h05);
        get(4'h3, 8'h06);
        $display("mode 0 gate and suspend done");
        put(4'h0, 8'h31);
        put(4'h1, 8'h00);
        put(4'h2, 8'h10);
        put(4'h2, 8'h00);
        ticks(0, 10);
        get(4'h3, 8'h06);
        ticks(0, 1);
        get(4'h3, 8'h07);
        $display("decimal count done");
        put(4'h4, 8'h05);
        put(4'h0, 8'h72);
        put(4'h0, 8'hBC);
        get(4'h3, 8'h07);
        for (int i = 0; i < 4; i++) begin
            put(4'h1, 8'(1 + i % 2));
            put(4'h2, (i < 2) ? 8'h03 : 8'h00);
        end
        ticks(1, 2);
        get(4'h3, 8'h07);
        put(4'h4, 8'h07);
        ticks(1, 3);
        get(4'h3, 8'h05);
        ticks(1, 1);
        get(4'h3, 8'h07);
        ticks(1, 4);
        get(4'h3, 8'h07);
        put(4'h1, 8'h01);
        put(4'h4, 8'h05);
        put(4'h4, 8'h07);
        ticks(1, 1);
        put(4'h2, 8'h04);
        put(4'h2, 8'h00);
        ticks(1, 2);
        get(4'h3, 8'h05);
        ticks(1, 1);
        get(4'h3, 8'h07);
        put(4'h4, 8'h05);
        put(4'h4, 8'h07);
        ticks(1, 4);
        get(4'h3, 8'h05);
        ticks(1, 1);
        get(4'h3, 8'h07);
        $display("one-shot done");
        ticks(2, 2);
        get(4'h3, 8'h07);
        ticks(2, 1);
        get(4'h3, 8'h03);
        put(4'h4, 8'h03);
        get(4'h3, 8'h07);
        put(4'h4, 8'h07);
        ticks(2, 2);
        get(4'h3, 8'h07);
        ticks(2, 1);
        get(4'h3, 8'h03);
        ticks(2, 1);
        get(4'h3, 8'h07);
        put(4'h1, 8'h02);
        put(4'h2, 8'h04);
        put(4'h2, 8'h00);
        ticks(2, 2);
        get(4'h3, 8'h03);
        ticks(2, 4);
        get(4'h3, 8'h03);
        ticks(2, 1);
        $display("rate generator done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            put(4'h6 + 4'(seed % 10), seed[15:8]);
            get(4'h6 + 4'(seed % 10), 8'h00);
        end
        get(4'h3, 8'h07);
        $display("unmapped access done");
        if (exp_q.size() != 0) begin
            num_errors++;
        end
        report_and_stop();
    end
endmodule
